// >>> dv/mab_tb.sv
/*
  Self-checking bench for the accumulator add/AND and bit-operation core.
  Assumes the core holds its own file memory, and that memory is X until written.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
  import mab_pkg::*;
  logic              clk;
  logic              rst;
  logic              opValid;
  mab_op_t           opCode;
  logic [DATA_W-1:0] opLiteral;
  logic [ADDR_W-1:0] opAddr;
  logic              opDest;
  logic [BIT_W-1:0]  opBit;
  logic [DATA_W-1:0] portPins;
  logic              prescalerToTimer;
  logic              readyQ;
  logic              doneQ;
  logic              discardQ;
  logic [DATA_W-1:0] accQ;
  logic              carryQ;
  logic              nibbleCarryFlagQ;
  logic              zeroQ;
  logic              prescalerClearQ;
  int                fails;
  int                samples_checked;
  int                mAcc;
  int                mC;
  int                mDc;
  int                mZ;
  int                mMem [128];
  int                regs [5] = '{16, 17, 127, 0, 1};

  mab_core dut (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode), .opLiteral(opLiteral),
    .opAddr(opAddr), .opDest(opDest), .opBit(opBit), .portPins(portPins),
    .prescalerToTimer(prescalerToTimer), .readyQ(readyQ), .doneQ(doneQ), .discardQ(discardQ),
    .accQ(accQ), .carryQ(carryQ), .nibbleCarryFlagQ(nibbleCarryFlagQ), .zeroQ(zeroQ),
    .prescalerClearQ(prescalerClearQ));

  // --------------------------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------------------------
  always #25 clk = ~clk;

  // Far beyond the several hundred cycles the tests need
  initial begin
    #(50 * 20000);
    fails++;
    end_sim();
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset with outputs checked while held; model flags and accumulator cleared, memory kept
  task automatic do_reset();
    int i;
    opValid = 1'b0;
    rst = 1'b1;
    repeat (16) @(negedge clk);
    `CHK("rst_ready", 0, readyQ)
    `CHK("rst_acc", 0, accQ)
    `CHK("rst_flags", 0, {carryQ, nibbleCarryFlagQ, zeroQ})
    rst = 1'b0;
    mAcc = 0; mC = 0; mDc = 0; mZ = 0;
    i = 0;
    while (readyQ !== 1'b1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    `CHK("ready", 1, readyQ)
  endtask

  // Entered at a falling edge with readyQ high; opValid stays up so ops can run back to back
  // Ops: 0 add imm, 1 add reg, 2 and imm, 3 and reg, 4 bit clear, 5 bit set, 6 skip low, 7 skip high
  task automatic run_op(input int op, input int lit, input int addr, input int dest, input int bt);
    int src, b, res, cyc, expCyc, skip, wr, seenDis, seenPre;
    opValid = 1'b1;
    opCode = mab_op_t'(op[2:0]);
    opLiteral = lit[7:0];
    opAddr = addr[6:0];
    opDest = dest[0];
    opBit = bt[2:0];
    @(posedge clk);
    cyc = 0; seenDis = 0; seenPre = 0; wr = 0; skip = 0;
    do begin
      @(negedge clk);
      cyc++;
      if (discardQ === 1'b1) seenDis = 1;
      if (prescalerClearQ === 1'b1) seenPre = 1;
    end while (doneQ !== 1'b1 && cyc < 8);
    // Port reads use the pin levels, not the stored latch
    src = (addr == IO_PORT_ADDR) ? portPins : mMem[addr];
    expCyc = 2;
    if (op < 4) begin
      b = op[0] ? src : lit;
      res = (op < 2) ? mAcc + b : mAcc & b;
      if (op < 2) begin
        mC = (res >> 8) & 1;
        mDc = ((mAcc & 15) + (b & 15)) >> 4;
      end
      res &= 255;
      mZ = (res == 0);
      if (op[0] && dest[0]) begin
        wr = 1;
        mMem[addr] = res;
      end else begin
        mAcc = res;
      end
      if (!op[0]) expCyc = 1;
    end else if (op < 6) begin
      res = (op == 4) ? src & ~(1 << bt) : src | (1 << bt);
      mMem[addr] = res & 255;
      wr = 1;
    end else begin
      skip = (((src >> bt) & 1) == (op == 7));
      expCyc = 2 + skip;
    end
    `CHK("cycles", expCyc, cyc)
    `CHK("acc", mAcc, accQ)
    `CHK("carry", mC, carryQ)
    `CHK("nibble", mDc, nibbleCarryFlagQ)
    `CHK("zero", mZ, zeroQ)
    `CHK("discard", skip, seenDis)
    `CHK("presclr", (wr && addr == TIMER_ZERO_COUNT_ADDR && prescalerToTimer), seenPre)
  endtask

  // Loads a file register; AND with zero first clears its unknown contents
  task automatic init_reg(input int a, input int v);
    run_op(2, 0, 0, 0, 0);
    run_op(3, 0, a, 1, 0);
    run_op(0, v, 0, 0, 0);
    run_op(1, 0, a, 1, 0);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; opValid = 1'b0; opCode = mab_op_t'(3'h0); opLiteral = 8'h00;
    opAddr = 7'h00; opDest = 1'b0; opBit = 3'h0; portPins = 8'h00; prescalerToTimer = 1'b0;
    fails = 0; samples_checked = 0;
    foreach (mMem[i]) mMem[i] = 0;
    void'($urandom(32'hE9C6));
    do_reset();
    // Immediate boundaries back to back: wrap to zero, nibble carry, AND to zero
    foreach (regs[i]) run_op(0, (i == 1) ? 8'h01 : 8'hFF, 0, 0, 0);
    run_op(0, 8'h88, 0, 0, 0);
    run_op(2, 8'hF0, 0, 0, 0);
    run_op(2, 8'h0F, 0, 0, 0);
    $display("test immediate done");
    // Registers incl. lowest, highest and timer count with prescaler assigned
    foreach (regs[i]) begin
      prescalerToTimer = (i == 4);
      init_reg(regs[i], 8'h5A + i * 8'h21);
    end
    $display("test registers done");
    // Every bit index set, cleared and tested both ways
    for (int bt = 0; bt < 8; bt++) begin
      run_op(5, 0, 16, 0, bt);
      run_op(4, 0, 17, 0, bt);
      for (int op = 6; op < 8; op++) begin
        run_op(op, 0, 16, 0, bt);
        run_op(op, 0, 17, 0, bt);
      end
    end
    $display("test bits done");
    // Random mix; pins change only between batches so the synchroniser settles
    for (int k = 0; k < 6; k++) begin
      opValid = 1'b0;
      portPins = $urandom;
      repeat (8) @(negedge clk);
      for (int n = 0; n < 40; n++) begin
        prescalerToTimer = $urandom;
        run_op($urandom % 8, $urandom % 256, (n % 6 == 5) ? IO_PORT_ADDR : regs[$urandom % 5],
          $urandom % 2, $urandom % 8);
      end
    end
    $display("test random done");
    // Reset in mid-run: accumulator and flags clear, file registers survive
    do_reset();
    run_op(1, 0, 16, 0, 0);
    run_op(3, 0, 127, 0, 0);
    $display("test second reset done");
    opValid = 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire

// >>> include/mab_mem_if.sv
/*
  Carrier between the datapath and its file register memory.
  Assumes one clock; read data are registered inside the memory.
*/
`timescale 1ns/1ps
`default_nettype none
interface mab_mem_if;
  import mab_pkg::*;
  logic                wrEn;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wrData;
  logic [DATA_W-1:0]   rdData;

  modport core (output wrEn, output addr, output wrData, input rdData);
  modport mem  (input wrEn, input addr, input wrData, output rdData);
endinterface
`default_nettype wire

// >>> include/mab_pkg.sv
/*
  Shared constants and types for the accumulator add and bit-operation datapath.
  Assumes a single core clock and a 128-entry byte-wide file register space.
*/
`default_nettype none
package mab_pkg;
  // ----------------------------------------------------------------------
  // Widths and address space
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned BIT_W   = 3;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned NIBBLE_W = 4;

  // ----------------------------------------------------------------------
  // File register locations with side effects
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] TIMER_ZERO_COUNT_ADDR = 7'h01;
  localparam logic [ADDR_W-1:0] IO_PORT_ADDR          = 7'h05;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] PORT_RESET = 8'h00;
  localparam logic              FLAG_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ADD_IMMEDIATE_TO_ACCUMULATOR,
    ADD_ACCUMULATOR_WITH_REGISTER,
    AND_IMMEDIATE_WITH_ACCUMULATOR,
    AND_ACCUMULATOR_WITH_REGISTER,
    REGISTER_BIT_CLEAR_OP,
    REGISTER_BIT_SET_OP,
    SKIP_WHEN_BIT_LOW_OP,
    SKIP_WHEN_BIT_HIGH_OP
  } mab_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_NOP
  } mab_state_t;
endpackage
`default_nettype wire

// >>> rtl/mab_core.sv
/*
  Accumulator add/AND and file register bit operations with bit-test skip.
  Assumes the decoder presents one operation at a time and holds it until taken,
  and that port pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module mab_core
  import mab_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              opValid,
  input  wire mab_op_t           opCode,
  input  wire logic [DATA_W-1:0] opLiteral,
  input  wire logic [ADDR_W-1:0] opAddr,
  input  wire logic              opDest,
  input  wire logic [BIT_W-1:0]  opBit,
  input  wire logic [DATA_W-1:0] portPins,
  input  wire logic              prescalerToTimer,
  output logic                   readyQ,
  output logic                   doneQ,
  output logic                   discardQ,
  output logic [DATA_W-1:0]      accQ,
  output logic                   carryQ,
  output logic                   nibbleCarryFlagQ,
  output logic                   zeroQ,
  output logic                   prescalerClearQ
);
  // ----------------------------------------------------------------------
  // Memory and pin synchroniser
  // ----------------------------------------------------------------------
  mab_mem_if memIf ();

  mab_file_mem #(
    .DEPTH (FILE_DEPTH)
  ) uMem (
    .clk   (clk),
    .memIf (memIf)
  );

  logic [DATA_W-1:0] pinS1Q;
  logic [DATA_W-1:0] pinS2Q;
  logic [DATA_W-1:0] pinS3Q;
  logic [DATA_W-1:0] pinLevelQ;
  logic [DATA_W-1:0] pinLevelD;

  // Per bit: a level is accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : gPin
      always_comb begin
        pinLevelD[gi] = (pinS2Q[gi] == pinS3Q[gi]) ? pinS2Q[gi] : pinLevelQ[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1Q    <= PORT_RESET;
      pinS2Q    <= PORT_RESET;
      pinS3Q    <= PORT_RESET;
      pinLevelQ <= PORT_RESET;
    end else begin
      pinS1Q    <= portPins;
      pinS2Q    <= pinS1Q;
      pinS3Q    <= pinS2Q;
      pinLevelQ <= pinLevelD;
    end
  end

  // ----------------------------------------------------------------------
  // Operand selection and shared adder
  // ----------------------------------------------------------------------
  mab_state_t        stateQ;
  mab_state_t        stateD;
  mab_op_t           opQ;
  mab_op_t           opD;
  logic [ADDR_W-1:0] addrQ;
  logic [ADDR_W-1:0] addrD;
  logic              destQ;
  logic              destD;
  logic [BIT_W-1:0]  bitQ;
  logic [BIT_W-1:0]  bitD;
  logic [DATA_W-1:0] srcW;
  logic [DATA_W-1:0] operandW;
  logic [DATA_W:0]   sumW;
  logic [NIBBLE_W:0] nibW;
  logic [DATA_W-1:0] maskW;
  logic              taken;

  assign taken = opValid && readyQ;

  // Port reads see the filtered pin levels so external drive wins over the latch
  assign srcW     = (addrQ == IO_PORT_ADDR) ? pinLevelQ : memIf.rdData;
  assign operandW = (stateQ == ST_READ) ? srcW : opLiteral;
  assign sumW     = {1'b0, accQ} + {1'b0, operandW};
  assign nibW     = {1'b0, accQ[NIBBLE_W-1:0]} + {1'b0, operandW[NIBBLE_W-1:0]};
  assign maskW    = DATA_W'(1) << bitQ;

  // ----------------------------------------------------------------------
  // Sequencer and result routing
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] accD;
  logic              carryD;
  logic              nibbleCarryD;
  logic              zeroD;
  logic              doneD;
  logic              discardD;
  logic              prescClrD;
  logic              readyD;
  logic              wrEnW;
  logic [DATA_W-1:0] wrDataW;
  logic [DATA_W-1:0] resW;

  always_comb begin
    stateD       = stateQ;
    opD          = opQ;
    addrD        = addrQ;
    destD        = destQ;
    bitD         = bitQ;
    accD         = accQ;
    carryD       = carryQ;
    nibbleCarryD = nibbleCarryFlagQ;
    zeroD        = zeroQ;
    doneD        = 1'b0;
    discardD     = 1'b0;
    wrEnW        = 1'b0;
    wrDataW      = srcW;
    resW         = sumW[DATA_W-1:0];
    case (stateQ)
      ST_IDLE: begin
        if (taken) begin
          case (opCode)
            ADD_IMMEDIATE_TO_ACCUMULATOR: begin
              accD         = sumW[DATA_W-1:0];
              carryD       = sumW[DATA_W];
              nibbleCarryD = nibW[NIBBLE_W];
              zeroD        = (sumW[DATA_W-1:0] == 8'h00);
              doneD        = 1'b1;
            end
            AND_IMMEDIATE_WITH_ACCUMULATOR: begin
              accD  = accQ & opLiteral;
              zeroD = ((accQ & opLiteral) == 8'h00);
              doneD = 1'b1;
            end
            default: begin
              // Register operands need one cycle for the registered read
              opD    = opCode;
              addrD  = opAddr;
              destD  = opDest;
              bitD   = opBit;
              stateD = ST_READ;
            end
          endcase
        end
      end
      ST_READ: begin
        stateD = ST_IDLE;
        doneD  = 1'b1;
        case (opQ)
          ADD_ACCUMULATOR_WITH_REGISTER, AND_ACCUMULATOR_WITH_REGISTER: begin
            if (opQ == ADD_ACCUMULATOR_WITH_REGISTER) begin
              resW         = sumW[DATA_W-1:0];
              carryD       = sumW[DATA_W];
              nibbleCarryD = nibW[NIBBLE_W];
            end else begin
              resW = accQ & srcW;
            end
            zeroD = (resW == 8'h00);
            if (destQ) begin
              wrEnW   = 1'b1;
              wrDataW = resW;
            end else begin
              accD = resW;
            end
          end
          REGISTER_BIT_CLEAR_OP: begin
            wrEnW   = 1'b1;
            wrDataW = srcW & ~maskW;
          end
          REGISTER_BIT_SET_OP: begin
            wrEnW   = 1'b1;
            wrDataW = srcW | maskW;
          end
          SKIP_WHEN_BIT_LOW_OP: begin
            if (!srcW[bitQ]) begin
              stateD   = ST_NOP;
              discardD = 1'b1;
              doneD    = 1'b0;
            end
          end
          SKIP_WHEN_BIT_HIGH_OP: begin
            if (srcW[bitQ]) begin
              stateD   = ST_NOP;
              discardD = 1'b1;
              doneD    = 1'b0;
            end
          end
          default: begin
            stateD = ST_IDLE;
          end
        endcase
      end
      ST_NOP: begin
        // The discarded slot: nothing is written and no flag moves
        stateD = ST_IDLE;
        doneD  = 1'b1;
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
    readyD    = (stateD == ST_IDLE);
    prescClrD = wrEnW && (addrQ == TIMER_ZERO_COUNT_ADDR) && prescalerToTimer;
  end

  assign memIf.wrEn   = wrEnW;
  assign memIf.wrData = wrDataW;
  // Address from the decoder while idle so the read data arrive in ST_READ
  assign memIf.addr   = (stateQ == ST_IDLE) ? opAddr : addrQ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ           <= ST_IDLE;
      opQ              <= ADD_IMMEDIATE_TO_ACCUMULATOR;
      addrQ            <= '0;
      destQ            <= 1'b0;
      bitQ             <= '0;
      accQ             <= ACC_RESET;
      carryQ           <= FLAG_RESET;
      nibbleCarryFlagQ <= FLAG_RESET;
      zeroQ            <= FLAG_RESET;
      doneQ            <= 1'b0;
      discardQ         <= 1'b0;
      readyQ           <= 1'b0;
      prescalerClearQ  <= 1'b0;
    end else begin
      stateQ           <= stateD;
      opQ              <= opD;
      addrQ            <= addrD;
      destQ            <= destD;
      bitQ             <= bitD;
      accQ             <= accD;
      carryQ           <= carryD;
      nibbleCarryFlagQ <= nibbleCarryD;
      zeroQ            <= zeroD;
      doneQ            <= doneD;
      discardQ         <= discardD;
      readyQ           <= readyD;
      prescalerClearQ  <= prescClrD;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_regTaken;
    taken && (opCode != ADD_IMMEDIATE_TO_ACCUMULATOR) && (opCode != AND_IMMEDIATE_WITH_ACCUMULATOR);
  endsequence
  sequence s_skipCycle;
    (stateQ == ST_NOP) && discardQ && !doneQ ##1 readyQ && doneQ;
  endsequence
  sequence s_flagsHeld;
    $stable(carryQ) && $stable(nibbleCarryFlagQ) && $stable(zeroQ);
  endsequence

  property p_addImm;
    taken && opCode == ADD_IMMEDIATE_TO_ACCUMULATOR |=>
      accQ == DATA_W'($past(accQ) + $past(opLiteral))
      && carryQ == ({1'b0, $past(accQ)} + {1'b0, $past(opLiteral)} > 9'h0FF)
      && zeroQ == (accQ == 8'h00) && doneQ;
  endproperty
  a_addImm: assert property (p_addImm) else $error("immediate add result or flags wrong");

  property p_andImm;
    taken && opCode == AND_IMMEDIATE_WITH_ACCUMULATOR |=>
      accQ == ($past(accQ) & $past(opLiteral)) && $stable(carryQ) && $stable(nibbleCarryFlagQ);
  endproperty
  a_andImm: assert property (p_andImm) else $error("immediate AND touched carry or wrong result");

  property p_regTiming;
    s_regTaken |=> (stateQ == ST_READ) && !readyQ ##1 (doneQ || discardQ);
  endproperty
  a_regTiming: assert property (p_regTiming) else $error("register operation timing wrong");

  property p_destReg;
    (stateQ == ST_READ) && destQ && (opQ == ADD_ACCUMULATOR_WITH_REGISTER || opQ == AND_ACCUMULATOR_WITH_REGISTER)
      |-> memIf.wrEn && memIf.addr == addrQ ##1 $stable(accQ);
  endproperty
  a_destReg: assert property (p_destReg) else $error("register destination not written back");

  property p_andRegFlags;
    (stateQ == ST_READ) && opQ == AND_ACCUMULATOR_WITH_REGISTER |=> $stable(carryQ) && $stable(nibbleCarryFlagQ);
  endproperty
  a_andRegFlags: assert property (p_andRegFlags) else $error("register AND changed carry");

  property p_bitClear;
    (stateQ == ST_READ) && opQ == REGISTER_BIT_CLEAR_OP |-> memIf.wrEn && !memIf.wrData[bitQ] ##1 s_flagsHeld;
  endproperty
  a_bitClear: assert property (p_bitClear) else $error("bit clear failed or flags moved");

  property p_bitSet;
    (stateQ == ST_READ) && opQ == REGISTER_BIT_SET_OP |-> memIf.wrEn && memIf.wrData[bitQ] ##1 s_flagsHeld;
  endproperty
  a_bitSet: assert property (p_bitSet) else $error("bit set failed or flags moved");

  property p_skipLow;
    (stateQ == ST_READ) && opQ == SKIP_WHEN_BIT_LOW_OP && !srcW[bitQ] |=> s_skipCycle;
  endproperty
  a_skipLow: assert property (p_skipLow) else $error("low-bit skip did not insert a no-op cycle");

  property p_skipHigh;
    (stateQ == ST_READ) && opQ == SKIP_WHEN_BIT_HIGH_OP |=>
      ((discardQ == $past(srcW[bitQ])) && (doneQ == !$past(srcW[bitQ])) && !$past(memIf.wrEn)) and s_flagsHeld;
  endproperty
  a_skipHigh: assert property (p_skipHigh) else $error("high-bit skip wrong");

  property p_prescaler;
    memIf.wrEn && memIf.addr == TIMER_ZERO_COUNT_ADDR && prescalerToTimer && stateQ == ST_READ |=> prescalerClearQ;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared on timer write");
endmodule
`default_nettype wire

// >>> rtl/mab_file_mem.sv
/*
  File register memory: single port, write-first free, registered read data.
  Assumes the core holds address stable for the cycle after a read request.
*/
`timescale 1ns/1ps
`default_nettype none
module mab_file_mem
  import mab_pkg::*;
#(
  parameter int unsigned DEPTH = FILE_DEPTH
) (
  input  wire logic clk,
  mab_mem_if.mem    memIf
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] store [DEPTH];
  logic [DATA_W-1:0] rdDataQ;
  logic [DATA_W-1:0] rdDataD;

  // Read returns old contents; in ST_READ the core reads and writes the same address together
  always_comb begin
    rdDataD = store[memIf.addr];
  end

  // No reset on the array: contents are undefined until software writes them
  always_ff @(posedge clk) begin
    rdDataQ <= rdDataD;
    if (memIf.wrEn) begin
      store[memIf.addr] <= memIf.wrData;
    end
  end

  assign memIf.rdData = rdDataQ;
endmodule
`default_nettype wire
